//--- rtl/phy_sec_params.svh
`ifndef PHY_SEC_PARAMS_SVH
`define PHY_SEC_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SEC_ADDR_W 8
`define SEC_IDX_SYM_ERR 8'h1A
`define SEC_IDX_SPECIAL 8'h1B
`define SEC_IDX_BASIC_CTRL 8'h20
`define SEC_IDX_RESET_CTRL 8'h21
`define SEC_IDX_HARDWARE_CONFIG_REG 8'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEC_BIT_SRC_SEL 15
`define SEC_BIT_AUTO_EN 14
`define SEC_BIT_MAN_STATE 13
`define SEC_BIT_HB_DIS 11
`define SEC_BIT_FAR_FAULT_INDICATION_ENABLE 5
`define SEC_BIT_TEN_MEG_POLARITY_REVERSED 4
`define SEC_BIT_SOFT_RST 0
`define SEC_BIT_PHY_RESET 1
`define SEC_BIT_STRAP_A 0
`define SEC_BIT_STRAP_B 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEC_SYM_ERR_RESET 16'h0000
`define SEC_SRC_SEL_RESET 1'b0
`define SEC_AUTO_EN_RESET 1'b0
`define SEC_MAN_STATE_RESET 1'b0
`define SEC_HB_DIS_RESET 1'b0
`define SEC_FEFI_FIBER 1'b1
`define SEC_FEFI_OTHER 1'b0

`endif

//--- rtl/phy_sec_pkg.sv
package phy_sec_pkg;

    typedef enum logic [1:0] {
        XOVER_STRAIGHT,
        XOVER_CROSS,
        XOVER_AUTO
    } xover_mode_type;

    typedef enum {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_type;

endpackage

//--- rtl/sym_err_if.sv
`timescale 1ns/1ps

interface sym_err_if #(
    parameter int COUNT_W = 16
);
    logic invalid_symbol;
    logic in_packet;
    logic ten_meg_mode;
    logic [COUNT_W-1:0] count;

    modport counter (
        input invalid_symbol,
        input in_packet,
        input ten_meg_mode,
        output count
    );

    modport user (
        output invalid_symbol,
        output in_packet,
        output ten_meg_mode,
        input count
    );
endinterface

//--- rtl/sym_err_counter.sv
`timescale 1ns/1ps
`include "phy_sec_params.svh"

module sym_err_counter #(
    parameter int COUNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    sym_err_if.counter link
);

    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic counted_reg;
    logic counted_next;
    logic bump;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        // Outside 10 Mbit/s mode idle errors count every time; inside a packet only the first
        bump = link.invalid_symbol && !link.ten_meg_mode
            && (!link.in_packet || !counted_reg);
        count_next = count_reg;
        if (bump) begin
            count_next = count_reg + 1'b1;
        end
        counted_next = link.in_packet && (counted_reg || bump);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_reg <= `SEC_SYM_ERR_RESET;
            counted_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            counted_reg <= counted_next;
        end
    end

    assign link.count = count_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_idle_error_counts;
        (rstn && link.invalid_symbol && !link.in_packet && !link.ten_meg_mode)
            |=> count_reg == $past(count_reg) + 1'b1;
    endproperty
    a_idle_error_counts: assert property (p_idle_error_counts)
        else $error("idle symbol error not counted");

    // Release edge itself is excluded: the count is still held in reset there
    sequence s_counted_in_packet;
        rstn && link.in_packet && bump;
    endsequence

    property p_once_per_packet;
        s_counted_in_packet ##1 link.in_packet |=> $stable(count_reg);
    endproperty
    a_once_per_packet: assert property (p_once_per_packet)
        else $error("counter advanced twice in one packet");

    property p_wraps;
        (bump && count_reg == {COUNT_W{1'b1}}) |=> count_reg == '0;
    endproperty
    a_wraps: assert property (p_wraps)
        else $error("counter did not wrap to zero");

    property p_ten_meg_hold;
        link.ten_meg_mode |=> $stable(count_reg);
    endproperty
    a_ten_meg_hold: assert property (p_ten_meg_hold)
        else $error("counter moved in 10 Mbit/s mode");

endmodule // sym_err_counter

//--- rtl/phy_symbol_error_and_crossover_ctrl.sv
`timescale 1ns/1ps
`include "phy_sec_params.svh"

module phy_symbol_error_and_crossover_ctrl #(
    parameter int COUNT_W = 16,
    parameter bit THIS_PORT_B = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [`SEC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_invalid_symbol,
    input wire logic rx_in_packet,
    input wire logic ten_meg_mode,
    input wire logic fiber_mode,
    input wire logic rx_polarity_reversed,
    input wire logic auto_strap,
    input wire logic manual_strap,
    input wire logic other_port_auto_strap,
    output logic [1:0] crossover_mode,
    output logic heartbeat_test_enable,
    output logic far_fault_indication_enable,
    output logic [COUNT_W-1:0] invalid_code_count
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [`SEC_ADDR_W-1:0] ADDR_SYM = `SEC_ADDR_W'(`SEC_IDX_SYM_ERR * 4);
    localparam logic [`SEC_ADDR_W-1:0] ADDR_SPC = `SEC_ADDR_W'(`SEC_IDX_SPECIAL * 4);
    localparam logic [`SEC_ADDR_W-1:0] ADDR_BAS = `SEC_ADDR_W'(`SEC_IDX_BASIC_CTRL * 4);
    localparam logic [`SEC_ADDR_W-1:0] ADDR_RST = `SEC_ADDR_W'(`SEC_IDX_RESET_CTRL * 4);
    localparam logic [`SEC_ADDR_W-1:0] ADDR_HWC = `SEC_ADDR_W'(`SEC_IDX_HARDWARE_CONFIG_REG * 4);

    phy_sec_pkg::bus_state_type bus_state_reg, bus_state_next;
    logic waitrequest_reg, waitrequest_next;
    logic [31:0] readdata_reg, readdata_next;

    logic src_sel_reg, src_sel_next;
    logic auto_en_reg, auto_en_next;
    logic man_state_reg, man_state_next;
    logic hb_dis_reg, hb_dis_next;
    logic fefi_reg, fefi_next;
    logic ten_meg_polarity_reversed_reg, ten_meg_polarity_reversed_next;
    logic soft_rst_reg, soft_rst_next;

    logic straps_taken_reg, straps_taken_next;
    logic strap_auto_reg, strap_auto_next;
    logic strap_man_reg, strap_man_next;
    logic strap_other_reg, strap_other_next;

    phy_sec_pkg::xover_mode_type xover_reg, xover_next;
    logic hb_en_reg, hb_en_next;
    logic fefi_out_reg, fefi_out_next;
    logic [COUNT_W-1:0] count_out_reg;

    logic request;
    logic commit;
    logic wr_lo;
    logic wr_hi;
    logic phy_reset;
    logic [15:0] special_view;
    logic [15:0] hardware_config_reg_view;

    sym_err_if #(.COUNT_W(COUNT_W)) err_link ();

    // ------------------------------------------------------------
    // Symbol error counter
    // ------------------------------------------------------------
    assign err_link.invalid_symbol = rx_invalid_symbol;
    assign err_link.in_packet = rx_in_packet;
    assign err_link.ten_meg_mode = ten_meg_mode;

    sym_err_counter #(.COUNT_W(COUNT_W)) u_counter (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .link(err_link)
    );

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------
    assign request = avs_read || avs_write;
    // A write lands only on the edge where waitrequest is seen low
    assign commit = avs_write && (bus_state_reg == phy_sec_pkg::BUS_ANSWER);
    assign wr_lo = commit && avs_byteenable[0];
    assign wr_hi = commit && avs_byteenable[1];

    always_comb begin
        // Reserved positions stay zero here
        special_view = '0;
        special_view[`SEC_BIT_SRC_SEL] = src_sel_reg;
        special_view[`SEC_BIT_AUTO_EN] = auto_en_reg;
        special_view[`SEC_BIT_MAN_STATE] = man_state_reg;
        special_view[`SEC_BIT_HB_DIS] = hb_dis_reg;
        special_view[`SEC_BIT_FAR_FAULT_INDICATION_ENABLE] = fefi_reg;
        special_view[`SEC_BIT_TEN_MEG_POLARITY_REVERSED] = ten_meg_polarity_reversed_reg;
        hardware_config_reg_view = '0;
        hardware_config_reg_view[`SEC_BIT_STRAP_A] = THIS_PORT_B ? strap_other_reg : strap_auto_reg;
        hardware_config_reg_view[`SEC_BIT_STRAP_B] = THIS_PORT_B ? strap_auto_reg : strap_other_reg;
    end

    always_comb begin
        bus_state_next = bus_state_reg;
        waitrequest_next = 1'b1;
        readdata_next = readdata_reg;
        case (bus_state_reg)
            phy_sec_pkg::BUS_IDLE: begin
                if (request) begin
                    bus_state_next = phy_sec_pkg::BUS_ANSWER;
                    waitrequest_next = 1'b0;
                    readdata_next = '0;
                    case (avs_address)
                        // Reading the counter has no side effect
                        ADDR_SYM: readdata_next[COUNT_W-1:0] = count_out_reg;
                        ADDR_SPC: readdata_next[15:0] = special_view;
                        ADDR_BAS: readdata_next[`SEC_BIT_SOFT_RST] = soft_rst_reg;
                        ADDR_HWC: readdata_next[15:0] = hardware_config_reg_view;
                        default: readdata_next = '0;
                    endcase
                end
            end
            phy_sec_pkg::BUS_ANSWER: begin
                bus_state_next = phy_sec_pkg::BUS_IDLE;
            end
            default: begin
                bus_state_next = phy_sec_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bus_state_reg <= phy_sec_pkg::BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            waitrequest_reg <= waitrequest_next;
            readdata_reg <= readdata_next;
        end
    end

    // ------------------------------------------------------------
    // Control and status bits
    // ------------------------------------------------------------
    assign phy_reset = wr_lo && (avs_address == ADDR_RST)
        && avs_writedata[`SEC_BIT_PHY_RESET] && soft_rst_reg;

    always_comb begin
        src_sel_next = src_sel_reg;
        auto_en_next = auto_en_reg;
        man_state_next = man_state_reg;
        hb_dis_next = hb_dis_reg;
        fefi_next = fefi_reg;
        soft_rst_next = soft_rst_reg;
        ten_meg_polarity_reversed_next = rx_polarity_reversed;
        if (wr_hi && (avs_address == ADDR_SPC)) begin
            src_sel_next = avs_writedata[`SEC_BIT_SRC_SEL];
            auto_en_next = avs_writedata[`SEC_BIT_AUTO_EN];
            man_state_next = avs_writedata[`SEC_BIT_MAN_STATE];
            hb_dis_next = avs_writedata[`SEC_BIT_HB_DIS];
        end
        if (wr_lo && (avs_address == ADDR_SPC)) begin
            fefi_next = avs_writedata[`SEC_BIT_FAR_FAULT_INDICATION_ENABLE];
        end
        if (wr_lo && (avs_address == ADDR_BAS)) begin
            soft_rst_next = avs_writedata[`SEC_BIT_SOFT_RST];
        end
        if (phy_reset) begin
            src_sel_next = `SEC_SRC_SEL_RESET;
            auto_en_next = `SEC_AUTO_EN_RESET;
            man_state_next = `SEC_MAN_STATE_RESET;
            hb_dis_next = `SEC_HB_DIS_RESET;
        end
        // Fiber level is only known after release, so load it on the first edge
        if (!straps_taken_reg) begin
            fefi_next = fiber_mode ? `SEC_FEFI_FIBER : `SEC_FEFI_OTHER;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            src_sel_reg <= `SEC_SRC_SEL_RESET;
            auto_en_reg <= `SEC_AUTO_EN_RESET;
            man_state_reg <= `SEC_MAN_STATE_RESET;
            hb_dis_reg <= `SEC_HB_DIS_RESET;
            fefi_reg <= `SEC_FEFI_OTHER;
            ten_meg_polarity_reversed_reg <= 1'b0;
            soft_rst_reg <= 1'b0;
        end else begin
            src_sel_reg <= src_sel_next;
            auto_en_reg <= auto_en_next;
            man_state_reg <= man_state_next;
            hb_dis_reg <= hb_dis_next;
            fefi_reg <= fefi_next;
            ten_meg_polarity_reversed_reg <= ten_meg_polarity_reversed_next;
            soft_rst_reg <= soft_rst_next;
        end
    end

    // ------------------------------------------------------------
    // Strap capture at reset release
    // ------------------------------------------------------------
    always_comb begin
        straps_taken_next = 1'b1;
        strap_auto_next = strap_auto_reg;
        strap_man_next = strap_man_reg;
        strap_other_next = strap_other_reg;
        if (!straps_taken_reg) begin
            strap_auto_next = auto_strap;
            strap_man_next = manual_strap;
            strap_other_next = other_port_auto_strap;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            straps_taken_reg <= 1'b0;
            strap_auto_reg <= 1'b0;
            strap_man_reg <= 1'b0;
            strap_other_reg <= 1'b0;
        end else begin
            straps_taken_reg <= straps_taken_next;
            strap_auto_reg <= strap_auto_next;
            strap_man_reg <= strap_man_next;
            strap_other_reg <= strap_other_next;
        end
    end

    // ------------------------------------------------------------
    // Crossover, heartbeat and far-end fault outputs
    // ------------------------------------------------------------
    always_comb begin
        if (src_sel_reg) begin
            // Reserved 11 falls to automatic; software must not use it
            if (auto_en_reg) begin
                xover_next = phy_sec_pkg::XOVER_AUTO;
            end else if (man_state_reg) begin
                xover_next = phy_sec_pkg::XOVER_CROSS;
            end else begin
                xover_next = phy_sec_pkg::XOVER_STRAIGHT;
            end
        end else begin
            if (strap_auto_reg) begin
                xover_next = phy_sec_pkg::XOVER_AUTO;
            end else if (strap_man_reg) begin
                xover_next = phy_sec_pkg::XOVER_CROSS;
            end else begin
                xover_next = phy_sec_pkg::XOVER_STRAIGHT;
            end
        end
        hb_en_next = !hb_dis_reg;
        fefi_out_next = fefi_reg;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            xover_reg <= phy_sec_pkg::XOVER_STRAIGHT;
            hb_en_reg <= 1'b1;
            fefi_out_reg <= 1'b0;
            count_out_reg <= '0;
        end else begin
            xover_reg <= xover_next;
            hb_en_reg <= hb_en_next;
            fefi_out_reg <= fefi_out_next;
            count_out_reg <= err_link.count;
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign crossover_mode = xover_reg;
    assign heartbeat_test_enable = hb_en_reg;
    assign far_fault_indication_enable = fefi_out_reg;
    assign invalid_code_count = count_out_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_reg_control;
        (src_sel_reg && !auto_en_reg && man_state_reg)
            |=> crossover_mode == phy_sec_pkg::XOVER_CROSS;
    endproperty
    a_reg_control: assert property (p_reg_control)
        else $error("register control did not force crossover");

    property p_strap_control;
        (!src_sel_reg && straps_taken_reg && strap_auto_reg)
            |=> crossover_mode == phy_sec_pkg::XOVER_AUTO;
    endproperty
    a_strap_control: assert property (p_strap_control)
        else $error("strap control did not give automatic mode");

    property p_strap_straight;
        (!src_sel_reg && !strap_auto_reg && !strap_man_reg)
            |=> crossover_mode == phy_sec_pkg::XOVER_STRAIGHT;
    endproperty
    a_strap_straight: assert property (p_strap_straight)
        else $error("straps 00 did not give straight-through");

    property p_reg_auto;
        (src_sel_reg && auto_en_reg && !man_state_reg)
            |=> crossover_mode == phy_sec_pkg::XOVER_AUTO;
    endproperty
    a_reg_auto: assert property (p_reg_auto)
        else $error("register 10 did not give automatic mode");

    property p_heartbeat;
        $rose(hb_dis_reg) |=> !heartbeat_test_enable;
    endproperty
    a_heartbeat: assert property (p_heartbeat)
        else $error("heartbeat test not suppressed");

    property p_fefi_follows;
        ##1 $changed(fefi_reg) |=> far_fault_indication_enable == $past(fefi_reg);
    endproperty
    a_fefi_follows: assert property (p_fefi_follows)
        else $error("far-end fault enable output lags its bit");

    property p_fefi_reset;
        (rstn && !straps_taken_reg) |=> fefi_reg == $past(fiber_mode);
    endproperty
    a_fefi_reset: assert property (p_fefi_reset)
        else $error("far-end fault enable reset value wrong");

    property p_polarity;
        rstn |=> ten_meg_polarity_reversed_reg == $past(rx_polarity_reversed);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity bit does not follow receiver");

    sequence s_phy_reset;
        phy_reset;
    endsequence

    property p_soft_reset;
        s_phy_reset |=> !src_sel_reg && !auto_en_reg && !man_state_reg && !hb_dis_reg;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft-reset-clearable bits not defaulted");

    property p_reserved_zero;
        !waitrequest_reg && (avs_address == ADDR_SPC) |-> (avs_readdata[12] == 1'b0)
            && (avs_readdata[10:6] == '0) && (avs_readdata[3:0] == '0)
            && (avs_readdata[31:16] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_read_no_clear;
        // Output copy lags the counter by one edge, so the previous symbol matters too
        (avs_read && !waitrequest_reg && avs_address == ADDR_SYM && !rx_invalid_symbol
            && !$past(rx_invalid_symbol))
            |=> count_out_reg == $past(count_out_reg);
    endproperty
    a_read_no_clear: assert property (p_read_no_clear)
        else $error("counter changed by a read");

endmodule // phy_symbol_error_and_crossover_ctrl

//--- dv/tb_top.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module tb_top;
    localparam logic [7:0] A_CNT = 8'h68;
    localparam logic [7:0] A_SPC = 8'h6C;
    localparam logic [7:0] A_BASIC = 8'h80;
    localparam logic [7:0] A_RST = 8'h84;
    localparam logic [7:0] A_HW = 8'h88;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h3;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_invalid_symbol = 1'b0;
    logic rx_in_packet = 1'b0;
    logic ten_meg_mode = 1'b0;
    logic fiber_mode = 1'b0;
    logic rx_polarity_reversed = 1'b0;
    logic auto_strap = 1'b0;
    logic manual_strap = 1'b1;
    logic other_port_auto_strap = 1'b1;
    logic [1:0] crossover_mode;
    logic heartbeat_test_enable;
    logic far_fault_indication_enable;
    logic [15:0] invalid_code_count;
    int n_fail = 0;
    int compares = 0;

    phy_symbol_error_and_crossover_ctrl phy_symbol_error_and_crossover_ctrl_inst (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .rx_invalid_symbol(rx_invalid_symbol),
        .rx_in_packet(rx_in_packet),
        .ten_meg_mode(ten_meg_mode),
        .fiber_mode(fiber_mode),
        .rx_polarity_reversed(rx_polarity_reversed),
        .auto_strap(auto_strap),
        .manual_strap(manual_strap),
        .other_port_auto_strap(other_port_auto_strap),
        .crossover_mode(crossover_mode),
        .heartbeat_test_enable(heartbeat_test_enable),
        .far_fault_indication_enable(far_fault_indication_enable),
        .invalid_code_count(invalid_code_count)
    );

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                       output logic [15:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0000, wd};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        rd = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Extra edge keeps the next request off this release step
        @(posedge clk_sys);
        if (n == 20) n_fail++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] x;
        bus(1'b1, a, d, x);
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] x;
        bus(1'b0, a, 16'h0000, x);
        `CHK(x, e)
    endtask

    task automatic hits(input int n);
        rx_invalid_symbol <= 1'b1;
        repeat (n) @(posedge clk_sys);
        rx_invalid_symbol <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic do_reset(input logic fib, input logic au, input logic man);
        rstn <= 1'b0;
        fiber_mode <= fib;
        auto_strap <= au;
        manual_strap <= man;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic report_and_stop;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog, sized well above the wrap run
    // ----------------------------------------
    initial begin
        repeat (95000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b0, 1'b0, 1'b1);
        `CHK(crossover_mode, 2'h1)
        `CHK(heartbeat_test_enable, 1'b1)
        `CHK(far_fault_indication_enable, 1'b0)
        check_reg(A_CNT, 16'h0000);
        check_reg(A_SPC, 16'h0000);
        check_reg(A_HW, 16'h0002);
        check_reg(8'h40, 16'h0000);
        hits(2);
        `CHK(invalid_code_count, 16'h0002)
        rx_in_packet <= 1'b1;
        hits(3);
        rx_in_packet <= 1'b0;
        `CHK(invalid_code_count, 16'h0003)
        ten_meg_mode <= 1'b1;
        hits(4);
        ten_meg_mode <= 1'b0;
        `CHK(invalid_code_count, 16'h0003)
        check_reg(A_CNT, 16'h0003);
        check_reg(A_CNT, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            wr(A_SPC, 16'h8000 | (16'(i) << 13));
            `CHK(crossover_mode, 2'(i))
        end
        rx_polarity_reversed <= 1'b1;
        wr(A_SPC, 16'hDFFF);
        check_reg(A_SPC, 16'hC830);
        `CHK(heartbeat_test_enable, 1'b0)
        `CHK(far_fault_indication_enable, 1'b1)
        // PHY reset without the soft reset bit must leave settings alone
        wr(A_RST, 16'h0002);
        check_reg(A_SPC, 16'hC830);
        wr(A_BASIC, 16'h0001);
        wr(A_RST, 16'h0002);
        check_reg(A_SPC, 16'h0030);
        `CHK(crossover_mode, 2'h1)
        `CHK(heartbeat_test_enable, 1'b1)
        rx_polarity_reversed <= 1'b0;
        do_reset(1'b1, 1'b1, 1'b0);
        `CHK(invalid_code_count, 16'h0000)
        `CHK(far_fault_indication_enable, 1'b1)
        `CHK(crossover_mode, 2'h2)
        check_reg(A_SPC, 16'h0020);
        check_reg(A_HW, 16'h0003);
        // Fiber port: software keeps automatic crossover off
        wr(A_SPC, 16'hA020);
        `CHK(crossover_mode, 2'h1)
        hits(65535);
        `CHK(invalid_code_count, 16'hFFFF)
        hits(1);
        `CHK(invalid_code_count, 16'h0000)
        report_and_stop();
    end
endmodule // tb_top
